/* File: core/bit_sync.sv */
// Purpose: Two flip-flop synchroniser for independent levels
// Assumes: Each bit is a level or a toggle held stable long enough
// Notes:   First stage feeds only the second stage
`timescale 1ns/1ns
`default_nettype none

module bit_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // Levels
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      meta_ff <= '0;
      sync_ff <= '0;
    end
    else
    begin
      meta_ff <= async_i;
      sync_ff <= meta_ff;
    end
  end

  assign sync_o = sync_ff;

endmodule

`default_nettype wire

/* File: core/eeprom_cmd_pkg.sv */
// Purpose: Shared constants and types for the serial memory command port
// Assumes: System clock of 100 MHz; link clock supplied by the external master
// Notes:   All timing counts are derived from times in their own units

package eeprom_cmd_pkg;

  // ************************************************************
  // Organization
  // ************************************************************
  localparam int BYTE_AW = 9;
  localparam int BYTE_DW = 8;
  localparam int WORD_AW = 8;
  localparam int WORD_DW = 16;

  // ************************************************************
  // Instruction encoding
  // ************************************************************
  localparam logic [1:0] OP_EXT    = 2'h0;
  localparam logic [1:0] OP_WRITE  = 2'h1;
  localparam logic [1:0] OP_READ   = 2'h2;
  localparam logic [1:0] OP_ERASE  = 2'h3;
  localparam logic [1:0] EXT_WDIS  = 2'h0;
  localparam logic [1:0] EXT_WRALL = 2'h1;
  localparam logic [1:0] EXT_ERALL = 2'h2;
  localparam logic [1:0] EXT_WEN   = 2'h3;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int NS_PER_MS     = 1000000;
  localparam int TCSL_NS       = 250;
  localparam int TWC_MS        = 6;
  localparam int TEC_MS        = 6;
  localparam int TWL_MS        = 15;
  // Longest times: integer division rounds down
  localparam int TWC_CYC       = TWC_MS * NS_PER_MS / CLK_PERIOD_NS;
  localparam int TEC_CYC       = TEC_MS * NS_PER_MS / CLK_PERIOD_NS;
  localparam int TWL_CYC       = TWL_MS * NS_PER_MS / CLK_PERIOD_NS;
  localparam int TMR_W         = 24;
  localparam int SYNC_W        = 6;

  // ************************************************************
  // State types
  // ************************************************************
  typedef enum logic [2:0] {
    LK_WAIT  = 3'h0,
    LK_SHIFT = 3'h1,
    LK_READ  = 3'h3,
    LK_DONE  = 3'h2
  } link_state_t;

  typedef enum logic [1:0] {
    PG_IDLE  = 2'h0,
    PG_SWEEP = 2'h1,
    PG_HOLD  = 2'h3
  } prog_state_t;

endpackage

/* File: core/eeprom_cmd_port.sv */
// Purpose: Three-wire serial command port of a small electrically erasable memory
// Assumes: clk_sys_i at 100 MHz, at least eight times the serial clock rate
// Notes:   Programming runs on clk_sys_i; the serial clock only shifts bits
//
// Overview of operation
// R1 - Select low means standby, but a running program cycle still completes.
// R2 - Master keeps select low at least 250 ns between instructions.
// R3 - Select low holds the instruction logic in reset, dropping partial input.
// R4 - Inputs sampled and output bits changed on the serial clock rising edge.
// R5 - Serial clock may pause at any level without losing position.
// R6 - Before a start bit, clock edges change nothing.
// R7 - Start bit is the first rising edge with select and data-in high.
// R8 - Execute only after all bits; then ignore input until a new start.
// R9 - Opcodes 11 erase, 10 read, 01 write; 00 uses two address MSBs.
// R10 - Byte mode: nine address bits, eight data; 12 or 20 clocks.
// R11 - Word mode: eight address bits, sixteen data; 11 or 27 clocks.
// R12 - Data out floats except reading or status; floats on select fall.
// R13 - Status drives low while busy, high when ready.
// R14 - Status shows on select re-raise after a started program cycle.
// R15 - Program cycles need no serial clock edges.
// R16 - Power-up is programming-disabled; enable needed before erase or write.
// R17 - Erase sets the location to ones; starts on select falling edge.
// R18 - Read emits a zero bit before the data bits.
// R19 - Select held high after read streams the following locations.
// R20 - Enable persists until disable; read ignores the enable state.
// R21 - Write-all erases the whole array, then writes data everywhere, if enabled.
// R22 - Erase-all sets the whole array to ones, starting on select fall.
// R23 - Programming disabled: erase and write instructions change nothing, no busy.
// R24 - Master polls status or waits before its next instruction.
`timescale 1ns/1ns
`default_nettype none

module eeprom_cmd_port #(
  parameter bit WORD_ORG = 1'b0,
  parameter int TWC_CYC  = eeprom_cmd_pkg::TWC_CYC,
  parameter int TEC_CYC  = eeprom_cmd_pkg::TEC_CYC,
  parameter int TWL_CYC  = eeprom_cmd_pkg::TWL_CYC
) (
  // System clock and reset
  input  wire logic clk_sys_i,
  input  wire logic rst_i,
  // Serial link
  input  wire logic sclk_i,
  input  wire logic cs_i,
  input  wire logic di_i,
  // Serial data out, three-state
  output logic      do_o,
  output logic      do_oe_o
);

  localparam int AW    = WORD_ORG ? eeprom_cmd_pkg::WORD_AW : eeprom_cmd_pkg::BYTE_AW;
  localparam int DW    = WORD_ORG ? eeprom_cmd_pkg::WORD_DW : eeprom_cmd_pkg::BYTE_DW;
  localparam int DEPTH = 1 << AW;
  localparam int TW    = eeprom_cmd_pkg::TMR_W;

  // ************************************************************
  // Link side
  // ************************************************************
  logic          start_tgl;
  logic          done_tgl;
  logic [1:0]    cmd_op;
  logic [AW-1:0] cmd_addr;
  logic [DW-1:0] cmd_data;
  logic          req_tgl;
  logic [AW-1:0] req_addr;
  logic          rd_en;
  logic          rd_bit;
  logic [DW-1:0] rd_w0_ff;
  logic [DW-1:0] rd_w1_ff;

  link_frontend #(
    .AW (AW),
    .DW (DW)
  ) u_link (
    .sclk_i      (sclk_i),
    .rst_i       (rst_i),
    .cs_i        (cs_i),
    .di_i        (di_i),
    .start_tgl_o (start_tgl),
    .done_tgl_o  (done_tgl),
    .cmd_op_o    (cmd_op),
    .cmd_addr_o  (cmd_addr),
    .cmd_data_o  (cmd_data),
    .req_tgl_o   (req_tgl),
    .req_addr_o  (req_addr),
    .rd_w0_i     (rd_w0_ff),
    .rd_w1_i     (rd_w1_ff),
    .rd_en_o     (rd_en),
    .rd_bit_o    (rd_bit)
  );

  // ************************************************************
  // Crossing into the system clock
  // ************************************************************
  logic [eeprom_cmd_pkg::SYNC_W-1:0] sync_vec;
  logic                              start_q_ff;
  logic                              done_q_ff;
  logic                              req_q_ff;

  bit_sync #(
    .W (eeprom_cmd_pkg::SYNC_W)
  ) u_sync (
    .clk_i   (clk_sys_i),
    .rst_i   (rst_i),
    .async_i ({cs_i, start_tgl, done_tgl, req_tgl, rd_en, rd_bit}),
    .sync_o  (sync_vec)
  );

  wire cs_s     = sync_vec[5];
  wire start_s  = sync_vec[4];
  wire done_s   = sync_vec[3];
  wire req_s    = sync_vec[2];
  wire rd_en_s  = sync_vec[1];
  wire rd_bit_s = sync_vec[0];
  wire start_ev = start_s ^ start_q_ff;
  wire done_ev  = done_s ^ done_q_ff;
  wire req_ev   = req_s ^ req_q_ff;

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      start_q_ff <= 1'b0;
      done_q_ff  <= 1'b0;
      req_q_ff   <= 1'b0;
    end
    else
    begin
      start_q_ff <= start_s;
      done_q_ff  <= done_s;
      req_q_ff   <= req_s;
    end
  end

  // ************************************************************
  // Instruction decode
  // ************************************************************
  wire [1:0] ext      = cmd_addr[AW-1:AW-2];
  wire       is_ext   = (cmd_op == eeprom_cmd_pkg::OP_EXT);                  // R9
  wire       is_wen   = is_ext & (ext == eeprom_cmd_pkg::EXT_WEN);
  wire       is_wdis  = is_ext & (ext == eeprom_cmd_pkg::EXT_WDIS);
  wire       is_prog  = (cmd_op == eeprom_cmd_pkg::OP_ERASE) |
                        (cmd_op == eeprom_cmd_pkg::OP_WRITE) |
                        (is_ext & (ext == eeprom_cmd_pkg::EXT_ERALL)) |
                        (is_ext & (ext == eeprom_cmd_pkg::EXT_WRALL));

  // ************************************************************
  // Enable state and pending program cycle
  // ************************************************************
  logic          wen_ff;
  logic          pend_ff;
  logic [1:0]    p_op_ff;
  logic [1:0]    p_ext_ff;
  logic [AW-1:0] p_addr_ff;
  logic [DW-1:0] p_data_ff;
  logic          armed_ff;

  eeprom_cmd_pkg::prog_state_t pst_ff;
  logic [AW-1:0] sw_addr_ff;
  logic          pass_ff;
  logic [TW-1:0] tmr_ff;
  logic [TW-1:0] limit_ff;

  wire p_is_ext = (p_op_ff == eeprom_cmd_pkg::OP_EXT);
  wire p_wrall  = p_is_ext & (p_ext_ff == eeprom_cmd_pkg::EXT_WRALL);
  wire p_erall  = p_is_ext & (p_ext_ff == eeprom_cmd_pkg::EXT_ERALL);
  wire p_all    = p_wrall | p_erall;
  wire p_ones   = (p_op_ff == eeprom_cmd_pkg::OP_ERASE) | p_erall | (p_wrall & ~pass_ff);
  wire idle     = (pst_ff == eeprom_cmd_pkg::PG_IDLE);
  // Cycle begins only once select has fallen after the instruction
  wire go       = pend_ff & ~cs_s & idle;                               // R17 R22
  wire sw_last  = (sw_addr_ff == AW'(DEPTH - 1));
  wire [TW-1:0] go_limit = p_wrall ? TW'(TWL_CYC) : (p_erall ? TW'(TEC_CYC) : TW'(TWC_CYC));

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      wen_ff    <= 1'b0;                                              // R16
      pend_ff   <= 1'b0;
      p_op_ff   <= '0;
      p_ext_ff  <= '0;
      p_addr_ff <= '0;
      p_data_ff <= '0;
    end
    else
    begin
      if (done_ev & is_wen)
      begin
        wen_ff <= 1'b1;                                               // R20
      end
      else if (done_ev & is_wdis)
      begin
        wen_ff <= 1'b0;
      end
      if (done_ev & is_prog & wen_ff)                                 // R23
      begin
        pend_ff   <= 1'b1;
        p_op_ff   <= cmd_op;
        p_ext_ff  <= ext;
        p_addr_ff <= cmd_addr;
        p_data_ff <= cmd_data;
      end
      else if (go)
      begin
        pend_ff <= 1'b0;
      end
    end
  end

  // ************************************************************
  // Self-timed program engine
  // ************************************************************
  // Runs on the system clock alone, so once started, select and serial clock are irrelevant
  always_ff @(posedge clk_sys_i or posedge rst_i)                     // R1 R15
  begin
    if (rst_i)
    begin
      pst_ff     <= eeprom_cmd_pkg::PG_IDLE;
      sw_addr_ff <= '0;
      pass_ff    <= 1'b0;
      tmr_ff     <= '0;
      limit_ff   <= '0;
    end
    else
    begin
      case (pst_ff)
        eeprom_cmd_pkg::PG_IDLE:
        begin
          if (go)
          begin
            pst_ff     <= eeprom_cmd_pkg::PG_SWEEP;
            sw_addr_ff <= p_all ? '0 : p_addr_ff;
            pass_ff    <= 1'b0;
            tmr_ff     <= '0;
            limit_ff   <= go_limit;
          end
        end
        eeprom_cmd_pkg::PG_SWEEP:
        begin
          tmr_ff <= tmr_ff + TW'(1);
          if (~p_all)
          begin
            pst_ff <= eeprom_cmd_pkg::PG_HOLD;
          end
          else if (sw_last & p_wrall & ~pass_ff)                     // R21
          begin
            pass_ff    <= 1'b1;
            sw_addr_ff <= '0;
          end
          else if (sw_last)
          begin
            pst_ff <= eeprom_cmd_pkg::PG_HOLD;
          end
          else
          begin
            sw_addr_ff <= sw_addr_ff + AW'(1);
          end
        end
        eeprom_cmd_pkg::PG_HOLD:
        begin
          tmr_ff <= tmr_ff + TW'(1);
          if (tmr_ff >= limit_ff)
          begin
            pst_ff <= eeprom_cmd_pkg::PG_IDLE;
          end
        end
        default:
        begin
          pst_ff <= eeprom_cmd_pkg::PG_IDLE;
        end
      endcase
    end
  end

  // ************************************************************
  // Array
  // ************************************************************
  logic [DW-1:0] mem [DEPTH];

  wire          wr_en   = (pst_ff == eeprom_cmd_pkg::PG_SWEEP);
  // Erase paths write all ones
  wire [DW-1:0] wr_data = p_ones ? {DW{1'b1}} : p_data_ff;            // R17 R22

  // Array contents are not reset: nonvolatile in intent
  always_ff @(posedge clk_sys_i)
  begin
    if (wr_en)
    begin
      mem[sw_addr_ff] <= wr_data;
    end
    if (req_ev)
    begin
      rd_w0_ff <= mem[req_addr];
      rd_w1_ff <= mem[req_addr + AW'(1)];
    end
  end

  // ************************************************************
  // Serial data out
  // ************************************************************
  wire busy   = ~idle;
  wire nxt_oe = cs_s & (rd_en_s | armed_ff);                          // R12 R14
  wire nxt_do = rd_en_s ? rd_bit_s : ~busy;                           // R13

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      armed_ff <= 1'b0;
      do_o     <= 1'b0;
      do_oe_o  <= 1'b0;
    end
    else
    begin
      // Status stays available until the next start bit
      if (go)
      begin
        armed_ff <= 1'b1;
      end
      else if (start_ev)
      begin
        armed_ff <= 1'b0;
      end
      do_o    <= nxt_do;
      do_oe_o <= nxt_oe;
    end
  end

endmodule

`default_nettype wire

/* File: core/link_frontend.sv */
// Purpose: Serial-clock side of the command port: start detect, shift, read out
// Assumes: Select low holds the instruction logic in reset, not the crossing words; link clock may stop at any level
// Notes:   Command words and request address are held stable for the system side
`timescale 1ns/1ns
`default_nettype none

module link_frontend #(
  parameter int AW = 9,
  parameter int DW = 8
) (
  // Link clock, resets and pins
  input  wire logic          sclk_i,
  input  wire logic          rst_i,
  input  wire logic          cs_i,
  input  wire logic          di_i,
  // Events towards the system side
  output logic               start_tgl_o,
  output logic               done_tgl_o,
  output logic [1:0]         cmd_op_o,
  output logic [AW-1:0]      cmd_addr_o,
  output logic [DW-1:0]      cmd_data_o,
  // Read fetch
  output logic               req_tgl_o,
  output logic [AW-1:0]      req_addr_o,
  input  wire logic [DW-1:0] rd_w0_i,
  input  wire logic [DW-1:0] rd_w1_i,
  // Read data out
  output logic               rd_en_o,
  output logic               rd_bit_o
);

  localparam int SRW = 2 + AW + DW;
  localparam int CW  = $clog2(SRW + 1);
  localparam int BW  = $clog2(DW + 1);

  eeprom_cmd_pkg::link_state_t state_ff;
  logic [CW-1:0]  cnt_ff;
  logic [SRW-1:0] sr_ff;
  logic [DW-1:0]  osr_ff;
  logic [BW-1:0]  bcnt_ff;
  logic           first_ff;
  logic [AW-1:0]  cur_ff;
  logic           rd_en_ff;
  logic           rd_bit_ff;
  logic           start_tgl_ff;
  logic           done_tgl_ff;
  logic           req_tgl_ff;
  logic [AW-1:0]  req_addr_ff;
  logic [1:0]     cmd_op_ff;
  logic [AW-1:0]  cmd_addr_ff;
  logic [DW-1:0]  cmd_data_ff;

  // Select low resets the instruction logic
  wire            link_rst = rst_i | ~cs_i;                          // R3
  wire [SRW-1:0]  nxt_sr   = {sr_ff[SRW-2:0], di_i};
  wire            in_shift = (state_ff == eeprom_cmd_pkg::LK_SHIFT);
  wire            in_read  = (state_ff == eeprom_cmd_pkg::LK_READ);
  wire            start_ev = (state_ff == eeprom_cmd_pkg::LK_WAIT) & di_i;   // R7
  wire            pre_edge = in_shift & (cnt_ff == CW'(AW));
  wire            adr_edge = in_shift & (cnt_ff == CW'(AW + 1));
  wire            dat_edge = in_shift & (cnt_ff == CW'(AW + DW + 1));
  wire [1:0]      pre_op   = nxt_sr[AW:AW-1];
  wire [1:0]      op_w     = nxt_sr[AW+1:AW];
  wire [1:0]      ext_w    = nxt_sr[AW-1:AW-2];
  wire [AW-1:0]   addr_w   = nxt_sr[AW-1:0];
  wire            is_read  = (op_w == eeprom_cmd_pkg::OP_READ);
  wire            has_data = (op_w == eeprom_cmd_pkg::OP_WRITE) |
                             ((op_w == eeprom_cmd_pkg::OP_EXT) &
                              (ext_w == eeprom_cmd_pkg::EXT_WRALL));
  wire            done_a   = adr_edge & ~is_read & ~has_data;        // R10 R11
  wire            done_ev  = done_a | dat_edge;                      // R8
  wire            load     = in_read & (bcnt_ff == '0);
  wire [DW-1:0]   word     = (first_ff & cur_ff[0]) ? rd_w1_i : rd_w0_i;

  // ************************************************************
  // Instruction sequencing, cleared by select low
  // ************************************************************
  always_ff @(posedge sclk_i or posedge link_rst)                    // R4 R5
  begin
    if (link_rst)
    begin
      state_ff  <= eeprom_cmd_pkg::LK_WAIT;
      cnt_ff    <= '0;
      sr_ff     <= '0;
      osr_ff    <= '0;
      bcnt_ff   <= '0;
      first_ff  <= 1'b0;
      cur_ff    <= '0;
      rd_en_ff  <= 1'b0;
      rd_bit_ff <= 1'b0;
    end
    else
    begin
      case (state_ff)
        eeprom_cmd_pkg::LK_WAIT:
        begin
          if (start_ev)                                              // R6
          begin
            state_ff <= eeprom_cmd_pkg::LK_SHIFT;
          end
        end
        eeprom_cmd_pkg::LK_SHIFT:
        begin
          sr_ff  <= nxt_sr;
          cnt_ff <= cnt_ff + CW'(1);
          if (adr_edge & is_read)
          begin
            // Dummy zero ahead of the data
            state_ff  <= eeprom_cmd_pkg::LK_READ;
            rd_en_ff  <= 1'b1;                                       // R18
            rd_bit_ff <= 1'b0;
            cur_ff    <= addr_w;
            first_ff  <= 1'b1;
          end
          else if (done_ev)
          begin
            state_ff <= eeprom_cmd_pkg::LK_DONE;
          end
        end
        eeprom_cmd_pkg::LK_READ:
        begin
          if (load)                                                  // R19
          begin
            rd_bit_ff <= word[DW-1];
            osr_ff    <= {word[DW-2:0], 1'b0};
            bcnt_ff   <= BW'(DW - 1);
            first_ff  <= 1'b0;
            cur_ff    <= cur_ff + AW'(1);
          end
          else
          begin
            rd_bit_ff <= osr_ff[DW-1];
            osr_ff    <= {osr_ff[DW-2:0], 1'b0};
            bcnt_ff   <= bcnt_ff - BW'(1);
          end
        end
        eeprom_cmd_pkg::LK_DONE:
        begin
          state_ff <= eeprom_cmd_pkg::LK_DONE;
        end
        default:
        begin
          state_ff <= eeprom_cmd_pkg::LK_WAIT;
        end
      endcase
    end
  end

  // ************************************************************
  // Crossing words, kept across select low
  // ************************************************************
  // These must survive deselect, or a toggle would fire on every select drop
  always_ff @(posedge sclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      start_tgl_ff <= 1'b0;
      done_tgl_ff  <= 1'b0;
      req_tgl_ff   <= 1'b0;
      req_addr_ff  <= '0;
      cmd_op_ff    <= '0;
      cmd_addr_ff  <= '0;
      cmd_data_ff  <= '0;
    end
    else
    begin
      if (cs_i & start_ev)
      begin
        start_tgl_ff <= ~start_tgl_ff;
      end
      if (cs_i & done_ev)
      begin
        done_tgl_ff <= ~done_tgl_ff;
        // Once data is in, the opcode sits above address and data
        cmd_op_ff   <= dat_edge ? nxt_sr[SRW-1:SRW-2] : op_w;            // R9
        cmd_addr_ff <= dat_edge ? nxt_sr[AW+DW-1:DW] : addr_w;
        cmd_data_ff <= dat_edge ? nxt_sr[DW-1:0] : '0;
      end
      // Fetch the even/odd pair one edge before the last address bit
      if (cs_i & pre_edge & (pre_op == eeprom_cmd_pkg::OP_READ))
      begin
        req_tgl_ff  <= ~req_tgl_ff;
        req_addr_ff <= {nxt_sr[AW-2:0], 1'b0};
      end
      else if (cs_i & load)
      begin
        req_tgl_ff  <= ~req_tgl_ff;
        req_addr_ff <= cur_ff + AW'(1);
      end
    end
  end

  assign start_tgl_o = start_tgl_ff;
  assign done_tgl_o  = done_tgl_ff;
  assign cmd_op_o    = cmd_op_ff;
  assign cmd_addr_o  = cmd_addr_ff;
  assign cmd_data_o  = cmd_data_ff;
  assign req_tgl_o   = req_tgl_ff;
  assign req_addr_o  = req_addr_ff;
  assign rd_en_o     = rd_en_ff;
  assign rd_bit_o    = rd_bit_ff;

endmodule

`default_nettype wire

/* File: tb/eeprom_cmd_port_asserts.sv */
// Purpose: Port checks for the serial memory command port
// Assumes: One clk_sys_i domain; link pins seen as plain levels
// Notes:   Bound to the top module from the bench
`timescale 1ns/1ns
`default_nettype none

module eeprom_cmd_port_asserts (
  // System side
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Link pins
  input wire logic sclk_i,
  input wire logic cs_i,
  input wire logic di_i,
  input wire logic do_o,
  input wire logic do_oe_o
);
  // ********
  // Checks
  // ********
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);

  // Link clock parked long enough for any output update to have landed
  sequence s_quiet;
    (cs_i && !sclk_i) [*5];
  endsequence
  sequence s_deselect;
    cs_i ##1 !cs_i;
  endsequence

  property p_float_idle;
    !cs_i [*4] |-> !do_oe_o;
  endproperty
  property p_float_fall;
    s_deselect |-> ##[0:3] !do_oe_o;
  endproperty
  property p_drive_sel;
    $rose(do_oe_o) |-> cs_i;
  endproperty
  property p_status_delay;
    $rose(do_oe_o) |-> $past(cs_i, 1);
  endproperty
  property p_oe_late;
    $rose(cs_i) |-> !do_oe_o;
  endproperty
  property p_standby;
    !cs_i ##1 !cs_i |=> !$rose(do_oe_o);
  endproperty
  property p_rst_quiet;
    $fell(rst_i) |-> !do_oe_o && !do_o;
  endproperty
  property p_no_fall_idle;
    s_quiet ##0 (do_oe_o && $past(do_oe_o) && $past(do_o)) |-> do_o;
  endproperty

  a_float_idle: assert property (p_float_idle) else $error("out driven deselected");
  a_float_fall: assert property (p_float_fall) else $error("out not released");
  a_drive_sel: assert property (p_drive_sel) else $error("out enabled unselected");
  a_status_delay: assert property (p_status_delay) else $error("out enabled early");
  a_oe_late: assert property (p_oe_late) else $error("out still on at select");
  a_standby: assert property (p_standby) else $error("out rose in standby");
  a_rst_quiet: assert property (p_rst_quiet) else $error("out active after reset");
  a_no_fall_idle: assert property (p_no_fall_idle) else $error("ready fell unclocked");
endmodule
`default_nettype wire

/* File: tb/eeprom_cmd_port_tb.sv */
// Purpose: Self-checking bench for the command port, byte organization
// Assumes: Short program times so cycles fit the run
// Notes:   Status is polled after every program cycle, before the next instruction
`timescale 1ns/1ns
`default_nettype none

module eeprom_cmd_port_tb;
  // ********
  // Harness
  // ********
  localparam int PCYC = 2000;
  logic      clk_sys_i;
  logic      rst_i;
  wire logic sclk_i;
  wire logic cs_i;
  wire logic di_i;
  wire logic do_o;
  wire logic do_oe_o;
  int        error_cnt;
  int        compares;

  initial
  begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end

  eeprom_cmd_port #(.WORD_ORG(1'b0), .TWC_CYC(PCYC), .TEC_CYC(PCYC), .TWL_CYC(PCYC)) i_dut (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .sclk_i(sclk_i), .cs_i(cs_i), .di_i(di_i),
    .do_o(do_o), .do_oe_o(do_oe_o));
  serial_master i_mst (
    .sclk_o(sclk_i), .cs_o(cs_i), .di_o(di_i), .do_i(do_o), .do_oe_i(do_oe_o));

  task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
    compares++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic stop_test();
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic prog(input logic [1:0] op, input logic [8:0] a, input logic [7:0] d,
                      input int n);
    i_mst.send({1'b1, op, a, d} >> (20 - n), n);
    i_mst.desel();
  endtask

  // Poll before the next instruction; link clock stays parked meanwhile
  task automatic status();
    int n;
    i_mst.sel();
    check("status on", {8'h0, do_oe_o}, 9'h001);
    check("busy", {8'h0, do_o}, 9'h000);
    n = 0;
    while (do_o !== 1'b1 && n < 6000)
    begin
      #10;
      n++;
    end
    check("ready", {8'h0, do_o}, 9'h001);
    i_mst.desel();
  endtask

  task automatic quiet();
    i_mst.sel();
    check("no status", {8'h0, do_oe_o}, 9'h000);
    i_mst.desel();
  endtask

  task automatic rd(input logic [8:0] a, input logic [7:0] d0, input logic [7:0] d1);
    i_mst.send({1'b1, eeprom_cmd_pkg::OP_READ, a, 8'h00} >> 8, 12);
    repeat (9) i_mst.clk_bit(1'b0);
    check("read", i_mst.rx[8:0], {1'b0, d0});
    #800;
    repeat (8) i_mst.clk_bit(1'b0);
    check("read next", {1'b0, i_mst.rx[7:0]}, {1'b0, d1});
    i_mst.desel();
    check("float", {8'h0, do_oe_o}, 9'h000);
  endtask

  // ********
  // Scenarios
  // ********
  task automatic t_locked();
    prog(eeprom_cmd_pkg::OP_ERASE, 9'h01f, 8'h00, 12);
    quiet();
  endtask

  task automatic t_write();
    prog(eeprom_cmd_pkg::OP_EXT, {eeprom_cmd_pkg::EXT_WEN, 7'h00}, 8'h00, 12);
    quiet();
    prog(eeprom_cmd_pkg::OP_WRITE, 9'h1ff, 8'ha5, 20);
    status();
    prog(eeprom_cmd_pkg::OP_WRITE, 9'h000, 8'h5a, 20);
    status();
    rd(9'h1ff, 8'ha5, 8'h5a);
  endtask

  task automatic t_erase();
    prog(eeprom_cmd_pkg::OP_ERASE, 9'h1ff, 8'h00, 12);
    status();
    rd(9'h1ff, 8'hff, 8'h5a);
    prog(eeprom_cmd_pkg::OP_EXT, {eeprom_cmd_pkg::EXT_ERALL, 7'h00}, 8'h00, 12);
    status();
    rd(9'h080, 8'hff, 8'hff);
    prog(eeprom_cmd_pkg::OP_EXT, {eeprom_cmd_pkg::EXT_WRALL, 7'h00}, 8'h3c, 20);
    status();
    rd(9'h100, 8'h3c, 8'h3c);
  endtask

  // Cut-off write must be dropped, then disable blocks a full write
  task automatic t_abort();
    prog(eeprom_cmd_pkg::OP_WRITE, 9'h005, 8'h00, 15);
    quiet();
    prog(eeprom_cmd_pkg::OP_EXT, {eeprom_cmd_pkg::EXT_WDIS, 7'h00}, 8'h00, 12);
    prog(eeprom_cmd_pkg::OP_WRITE, 9'h100, 8'h00, 20);
    quiet();
    rd(9'h100, 8'h3c, 8'h3c);
  endtask

  initial
  begin
    error_cnt = 0;
    compares = 0;
    rst_i = 1'b1;
    repeat (12) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
    #3;
    t_locked();
    t_write();
    t_erase();
    t_abort();
    stop_test();
  end

  initial
  begin
    #900000;
    error_cnt++;
    stop_test();
  end
endmodule

bind eeprom_cmd_port eeprom_cmd_port_asserts i_chk (
  .clk_sys_i(clk_sys_i), .rst_i(rst_i), .sclk_i(sclk_i), .cs_i(cs_i), .di_i(di_i),
  .do_o(do_o), .do_oe_o(do_oe_o));
`default_nettype wire

/* File: tb/serial_master.sv */
// Purpose: Serial bus master driving select, link clock and data in
// Assumes: Link clock period 160 ns, running only inside frames
// Notes:   rx collects data out sampled just before each rising edge
`timescale 1ns/1ns
`default_nettype none

module serial_master (
  // Pins towards the port
  output logic      sclk_o,
  output logic      cs_o,
  output logic      di_o,
  input  wire logic do_i,
  input  wire logic do_oe_i
);
  // ********
  // Bit level
  // ********
  logic [31:0] rx;

  initial
  begin
    sclk_o = 1'b0;
    cs_o = 1'b0;
    di_o = 1'b0;
    rx = 32'h0;
  end

  task automatic clk_bit(input logic b);
    di_o = b;
    #80;
    rx = {rx[30:0], do_oe_i ? do_i : 1'bx};
    sclk_o = 1'b1;
    #80;
    sclk_o = 1'b0;
  endtask

  // Idle zeros ahead of the start bit must change nothing
  task automatic send(input logic [19:0] v, input int n);
    cs_o = 1'b1;
    repeat (3) clk_bit(1'b0);
    for (int i = n - 1; i >= 0; i--)
      clk_bit(v[i]);
  endtask

  task automatic sel();
    cs_o = 1'b1;
    #100;
  endtask

  // Released data line shows garbage, not the last bit
  task automatic desel();
    cs_o = 1'b0;
    di_o = ~di_o;
    #300;
  endtask
endmodule
`default_nettype wire
